// ### hdl/hub_config_status_command_reg.sv
// Purpose: device status and command register of the hub configuration space
// Assumes: byte-wide register port from the serial slave, same clock
// Notes: reload strobe tells every other configuration register to take its reset value
`timescale 1ns/1ps
module hub_config_status_command_reg (
    input wire logic clk,
    input wire logic reset,
    input wire logic [hub_status_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [hub_status_pkg::DATA_W-1:0] regWriteData,
    input wire logic configModeEnter,
    output logic [hub_status_pkg::DATA_W-1:0] regReadData,
    output logic configReload,
    output logic upstreamConnectAllow
);
    import hub_status_pkg::*;

    typedef struct packed {
        logic softReset;
        logic cfgProgress;
        logic [DATA_W-1:0] readData;
        logic connectAllow;
        logic reloadPending;
        logic reloadStrobe;
        logic [RELOAD_CNT_W-1:0] strobeLen;
    } reg_s;

    reg_s state;
    reg_s next_state;
    logic hit;
    logic reloadActive;
    logic reloadDone;
    logic reloadStart;

    function automatic logic [DATA_W-1:0] pack_status(input logic sr, input logic cp);
        logic [DATA_W-1:0] v;
        v = '0;
        v[SOFT_RESET_BIT] = sr;
        v[CFG_PROGRESS_BIT] = cp;
        return v & ~RESERVED_MASK;
    endfunction : pack_status

    // one written into the given bit position of this register
    function automatic logic write_one(input logic we, input logic sel,
        input logic [DATA_W-1:0] data, input int pos);
        return we && sel && data[pos];
    endfunction : write_one

    assign hit = (regAddr == STATUS_CMD_OFFSET);
    assign reloadStart = state.reloadPending;

    reload_sequencer #(
        .CYCLES(RELOAD_CYCLES)
    ) u_reload (
        .clk(clk),
        .reset(reset),
        .start(reloadStart),
        .reloadActive(reloadActive),
        .done(reloadDone)
    );

    always_comb begin
        logic wrSr;
        logic wrCp;
        wrSr = write_one(regWrite, hit, regWriteData, SOFT_RESET_BIT);
        wrCp = write_one(regWrite, hit, regWriteData, CFG_PROGRESS_BIT);
        next_state = state;
        next_state.reloadPending = 1'b0;
        // set by write; a new write while busy is ignored and does not hold off the clear at reloadDone
        if (wrSr && !state.softReset) begin
            next_state.softReset = 1'b1;
            next_state.reloadPending = 1'b1;
        end else if (reloadDone) begin
            next_state.softReset = 1'b0;
        end
        // hardware set wins over a clear in the same cycle
        if (configModeEnter) begin
            next_state.cfgProgress = 1'b1;
        end else if (wrCp) begin
            next_state.cfgProgress = 1'b0;
        end
        next_state.connectAllow = !next_state.cfgProgress;
        if (regRead && hit) begin
            next_state.readData = pack_status(next_state.softReset, next_state.cfgProgress);
        end else if (regRead) begin
            next_state.readData = '0;
        end
        // strobe lags the sequencer by one edge
        next_state.reloadStrobe = reloadActive;
        // length of the running strobe, checked below
        if (state.reloadStrobe) begin
            next_state.strobeLen = state.strobeLen + RELOAD_CNT_W'(1);
        end else begin
            next_state.strobeLen = '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign regReadData = state.readData;
    assign configReload = state.reloadStrobe;
    assign upstreamConnectAllow = state.connectAllow;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // register read port and writes to the reserved bits
    a_reserved_zero: assert property (regReadData[DATA_W-1:2] == '0)
        else $error("reserved bits read nonzero");

    a_read_status: assert property (regRead && hit |=>
        regReadData[SOFT_RESET_BIT] == state.softReset
        && regReadData[CFG_PROGRESS_BIT] == state.cfgProgress)
        else $error("status read does not match register");

    a_unmapped_zero: assert property (regRead && !hit |=> regReadData == '0)
        else $error("unmapped read not zero");

    a_upper_ignored: assert property (regWrite && hit && regWriteData[1:0] == 2'b00
        && !configModeEnter && !reloadDone
        |=> state.softReset == $past(state.softReset)
        && state.cfgProgress == $past(state.cfgProgress))
        else $error("reserved write changed state");

    // soft reset and reload
    a_soft_set: assert property (regWrite && hit && regWriteData[SOFT_RESET_BIT]
        && !state.softReset |=> state.softReset)
        else $error("soft reset not set by write");

    a_soft_zero_write: assert property (regWrite && hit && !regWriteData[SOFT_RESET_BIT]
        && !state.softReset |=> !state.softReset)
        else $error("zero write set soft reset");

    a_soft_only_write: assert property (!state.softReset
        && !(regWrite && hit && regWriteData[SOFT_RESET_BIT]) |=> !state.softReset)
        else $error("soft reset set without a write");

    a_other_addr: assert property (regWrite && !hit && !state.softReset
        |=> !state.softReset)
        else $error("write elsewhere set soft reset");

    a_reload_clears: assert property ($rose(state.softReset)
        |-> ##[1:20] !state.softReset)
        else $error("soft reset never cleared");

    a_reload_strobe: assert property ($rose(state.softReset)
        |-> ##[1:4] configReload)
        else $error("no reload after soft reset");

    a_reload_starts: assert property ($rose(state.softReset) |=> reloadActive)
        else $error("reload did not start");

    a_pending_pulse: assert property (reloadStart |=> !reloadStart)
        else $error("reload start longer than one cycle");

    a_busy_ignored: assert property (regWrite && hit && regWriteData[SOFT_RESET_BIT]
        && state.softReset |=> !reloadStart)
        else $error("second reload started while busy");

    a_reload_inside: assert property (reloadActive |-> state.softReset)
        else $error("reload running without soft reset");

    a_strobe_inside: assert property (configReload |-> state.softReset)
        else $error("reload strobe without soft reset");

    a_soft_keep: assert property (state.softReset && !reloadDone |=> state.softReset)
        else $error("soft reset cleared before reload end");

    a_done_clears: assert property (reloadDone |=> !state.softReset)
        else $error("soft reset kept after reload done");

    a_strobe_length: assert property ($fell(configReload)
        |-> state.strobeLen == RELOAD_CNT_W'(RELOAD_CYCLES))
        else $error("reload strobe length wrong");

    // configuration mode and upstream connect
    a_mode_sets: assert property (configModeEnter |=> state.cfgProgress)
        else $error("progress bit not set on mode entry");

    a_hold_disc: assert property (state.cfgProgress |-> !upstreamConnectAllow)
        else $error("upstream connected during configuration");

    a_connect_mode: assert property (configModeEnter |=> !upstreamConnectAllow)
        else $error("upstream allowed on mode entry");

    a_progress_clear: assert property (regWrite && hit && regWriteData[CFG_PROGRESS_BIT]
        && !configModeEnter |=> !state.cfgProgress)
        else $error("progress bit not cleared by write");

    a_progress_keep: assert property (regWrite && hit && !regWriteData[CFG_PROGRESS_BIT]
        && state.cfgProgress |=> state.cfgProgress)
        else $error("zero write cleared progress bit");

    a_connect_free: assert property (regWrite && hit && regWriteData[CFG_PROGRESS_BIT]
        && !configModeEnter |=> upstreamConnectAllow)
        else $error("upstream still held after clear");

    a_both_bits: assert property (regWrite && hit && (regWriteData[1:0] == 2'b11)
        && !configModeEnter && !state.softReset
        |=> state.softReset && !state.cfgProgress)
        else $error("combined write mishandled");

    c_soft_reset: cover property ($fell(state.softReset));
    c_connect: cover property ($rose(upstreamConnectAllow));
    c_both: cover property (regWrite && hit && (regWriteData[1:0] == 2'b11));
    c_collide: cover property (configModeEnter && write_one(regWrite, hit, regWriteData,
        CFG_PROGRESS_BIT));
    c_strobe_end: cover property ($fell(configReload));
endmodule : hub_config_status_command_reg

// ### hdl/hub_status_pkg.sv
// Purpose: constants for the hub status and command register block
// Assumes: 8-bit register port inside the hub configuration space
// Notes: soft reload length is a plain default
package hub_status_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] STATUS_CMD_OFFSET = 8'hF8;
    localparam logic [DATA_W-1:0] STATUS_CMD_RESET = 8'h00;
    localparam int SOFT_RESET_BIT = 1;
    localparam int CFG_PROGRESS_BIT = 0;
    localparam logic [DATA_W-1:0] RESERVED_MASK = 8'hFC;
    localparam int RELOAD_CYCLES = 4;
    localparam int RELOAD_CNT_W = 8;
endpackage : hub_status_pkg

// ### hdl/reload_sequencer.sv
// Purpose: times the reload of configuration registers during a soft reset
// Assumes: start is a one-cycle pulse from the status register logic
// Notes: reload strobe stands for the whole reload, done pulses at its end
`timescale 1ns/1ps
module reload_sequencer #(
    parameter int CYCLES = hub_status_pkg::RELOAD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    output logic reloadActive,
    output logic done
);
    import hub_status_pkg::*;

    typedef struct packed {
        logic busy;
        logic doneQ;
        logic [RELOAD_CNT_W-1:0] count;
    } seq_s;

    seq_s state;
    seq_s next_state;

    always_comb begin
        next_state = state;
        next_state.doneQ = 1'b0;
        if (!state.busy && start) begin
            next_state.busy = 1'b1;
            next_state.count = RELOAD_CNT_W'(CYCLES - 1);
        end else if (state.busy) begin
            if (state.count == '0) begin
                next_state.busy = 1'b0;
                next_state.doneQ = 1'b1;
            end else begin
                next_state.count = state.count - RELOAD_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reloadActive = state.busy;
    assign done = state.doneQ;
endmodule : reload_sequencer

// ### tb/host_model.sv
// Purpose: register host for the status and command port
// Assumes: strobes change at the falling edge, one cycle each
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic [hub_status_pkg::ADDR_W-1:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [hub_status_pkg::DATA_W-1:0] regWriteData,
    input wire logic [hub_status_pkg::DATA_W-1:0] regReadData
);
    import hub_status_pkg::*;
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWriteData = 8'h00;
    end
    // host sets soft reset and clears progress via the slave port
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regAddr = ~a;
        regWriteData = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        regAddr = ~a;
        d = regReadData;
    endtask : rd
endmodule : host_model

// ### tb/hub_config_status_command_reg_bench.sv
// Purpose: self-checking bench of the status and command register
// Assumes: host model drives the register port at falling edges
// Notes: reload length taken from the package default
`timescale 1ns/1ps
module hub_config_status_command_reg_bench;
    import hub_status_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic configModeEnter = 1'b0;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWriteData, regReadData, v;
    logic regWrite, regRead, configReload, upstreamConnectAllow;
    int failures = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    hub_config_status_command_reg u_hub_config_status_command_reg (.clk(clk), .reset(reset),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWriteData(regWriteData), .configModeEnter(configModeEnter),
        .regReadData(regReadData), .configReload(configReload),
        .upstreamConnectAllow(upstreamConnectAllow));
    host_model u_host_model (.clk(clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] e);
        u_host_model.rd(STATUS_CMD_OFFSET, v);
        chk(v, e);
    endtask : rdchk
    task automatic enter_mode;
        @(negedge clk);
        configModeEnter = 1'b1;
        @(negedge clk);
        configModeEnter = 1'b0;
    endtask : enter_mode
    task automatic reload_len;
        int n;
        n = 0;
        repeat (20) if (configReload !== 1'b1) @(negedge clk);
        while (configReload === 1'b1 && n < 50) begin
            n++;
            @(negedge clk);
        end
        chk(n[7:0], RELOAD_CYCLES[7:0]);
    endtask : reload_len
    task automatic test_mode;
        rdchk(STATUS_CMD_RESET);
        chk({7'h00, upstreamConnectAllow}, 8'h01);
        enter_mode();
        rdchk(8'h01);
        chk({7'h00, upstreamConnectAllow}, 8'h00);
        u_host_model.wr(STATUS_CMD_OFFSET, 8'h00);
        rdchk(8'h01);
        u_host_model.wr(STATUS_CMD_OFFSET, 8'hFC);
        rdchk(8'h01);
        u_host_model.rd(8'hF0, v);
        chk(v, 8'h00);
        u_host_model.wr(8'hF0, 8'h03);
        rdchk(8'h01);
        chk({7'h00, configReload}, 8'h00);
        u_host_model.wr(STATUS_CMD_OFFSET, 8'h01);
        rdchk(8'h00);
        chk({7'h00, upstreamConnectAllow}, 8'h01);
        $display("test_mode done");
    endtask : test_mode
    task automatic test_collide;
        fork
            enter_mode();
            u_host_model.wr(STATUS_CMD_OFFSET, 8'h01);
        join
        rdchk(8'h01);
        chk({7'h00, upstreamConnectAllow}, 8'h00);
        u_host_model.wr(STATUS_CMD_OFFSET, 8'h01);
        rdchk(8'h00);
        chk({7'h00, upstreamConnectAllow}, 8'h01);
        $display("test_collide done");
    endtask : test_collide
    task automatic test_soft(input logic [7:0] d);
        u_host_model.wr(STATUS_CMD_OFFSET, d);
        fork
            reload_len();
            rdchk(8'h02);
        join
        chk({7'h00, upstreamConnectAllow}, 8'h01);
        rdchk(8'h00);
        $display("test_soft %h done", d);
    endtask : test_soft
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        test_mode();
        test_collide();
        test_soft(8'h02);
        enter_mode();
        test_soft(8'h03);
        end_sim();
    end
endmodule : hub_config_status_command_reg_bench
